// ==== src/t3rt_map.svh ====
`ifndef T3RT_MAP_SVH
`define T3RT_MAP_SVH

// ***************************************************************
// Register indices; byte address is four times the index.
// ***************************************************************
`define T3RT_IDX_W 10
`define T3RT_IDX_CTRL 10'h091
`define T3RT_IDX_RLL 10'h092
`define T3RT_IDX_RLH 10'h093
`define T3RT_IDX_CNTL 10'h094
`define T3RT_IDX_CNTH 10'h095
`define T3RT_IDX_CLKSEL 10'h096
`define T3RT_IDX_STATUS 10'h097
`define T3RT_IDX_MASK 10'h098

// ***************************************************************
// Field positions of the timer control register.
// ***************************************************************
`define T3RT_CTL_TFH 7
`define T3RT_CTL_TFL 6
`define T3RT_CTL_LIE 5
`define T3RT_CTL_CAP 4
`define T3RT_CTL_SPLIT 3
`define T3RT_CTL_RUN 2
`define T3RT_CTL_SRC_HI 1
`define T3RT_CTL_SRC_LO 0

// ***************************************************************
// Clock select bits and interrupt status bits.
// ***************************************************************
`define T3RT_CKS_LO 0
`define T3RT_CKS_HI 1
`define T3RT_ST_HIGH 0
`define T3RT_ST_LOW 1
`define T3RT_ST_CAP 2

// ***************************************************************
// Reset values, dividers and bus answers.
// ***************************************************************
`define T3RT_RST_BYTE 8'h00
`define T3RT_RST_CNT 16'h0000
`define T3RT_DIV12_LAST 4'hb
`define T3RT_OSC8_LAST 3'h7
`define T3RT_RESP_OKAY 2'h0
`define T3RT_RESP_SLVERR 2'h2

`endif

// ==== src/t3rt_pkg.sv ====
`include "t3rt_map.svh"

package t3rt_pkg;

	// State of the timer block, apart from the two reset release flip-flops.
	typedef struct packed {
		logic cmp_s1;
		logic cmp_s2;
		logic cmp_s3;
		logic osc_s1;
		logic osc_s2;
		logic osc_s3;
		logic [3:0] div12;
		logic [2:0] osc8;
		logic [7:0] ctrl;
		logic [1:0] clksel;
		logic [15:0] rl;
		logic [15:0] cnt;
		logic [2:0] status;
		logic [2:0] mask;
		logic irq;
		logic aw_held;
		logic [`T3RT_IDX_W-1:0] aw_idx;
		logic w_held;
		logic [7:0] w_data;
		logic w_strb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
	} t3rt_state_s;

endpackage

// ==== src/t3rt_timer.sv ====
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
`include "t3rt_map.svh"

module t3rt_timer (
	input wire logic CORE_CLK_I, // System clock, 125 MHz.
	input wire logic RSTN_I, // Asynchronous active-low reset.
	input wire logic CE_I, // Clock enable; state freezes while low.
	input wire logic CMP1_I, // Comparator output, asynchronous.
	input wire logic EXTOSC_I, // External oscillator clock, asynchronous.
	input wire logic [11:0] AXI_AWADDR_I, // Write address.
	input wire logic AXI_AWVALID_I, // Write address valid.
	output logic AXI_AWREADY_O, // Write address ready.
	input wire logic [31:0] AXI_WDATA_I, // Write data.
	input wire logic [3:0] AXI_WSTRB_I, // Write byte strobes.
	input wire logic AXI_WVALID_I, // Write data valid.
	output logic AXI_WREADY_O, // Write data ready.
	output logic [1:0] AXI_BRESP_O, // Write response.
	output logic AXI_BVALID_O, // Write response valid.
	input wire logic AXI_BREADY_I, // Write response ready.
	input wire logic [11:0] AXI_ARADDR_I, // Read address.
	input wire logic AXI_ARVALID_I, // Read address valid.
	output logic AXI_ARREADY_O, // Read address ready.
	output logic [31:0] AXI_RDATA_O, // Read data.
	output logic [1:0] AXI_RRESP_O, // Read response.
	output logic AXI_RVALID_O, // Read data valid.
	input wire logic AXI_RREADY_I, // Read data ready.
	output logic IRQ_O // Level interrupt, high while unmasked status is set; low overflow also needs its enable.
);

	// ***************************************************************
	// Reset release
	// ***************************************************************

	logic rst_meta_r;
	logic rstn_r;

	// Releases the asynchronous reset through two flip-flops.
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_meta_r <= 1'b0;
			rstn_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rstn_r <= rst_meta_r;
		end
	end

	// ***************************************************************
	// Source selection
	// ***************************************************************

	t3rt_pkg::t3rt_state_s q_r;
	t3rt_pkg::t3rt_state_s q_nxt;
	logic cmp_rise;
	logic osc_rise;
	logic div_tick;
	logic osc_tick;
	logic ext_tick;
	logic cap_evt;
	logic lo_tick;
	logic hi_tick;
	logic cap_mode;
	logic split;
	logic do_wr;
	logic wr_en;
	logic cnt_wr;
	logic ctrl_wr;
	logic [`T3RT_IDX_W-1:0] ar_idx;
	logic [7:0] rd_byte;
	logic rd_hit;

	// Edges are taken from the second and third stages only.
	assign cmp_rise = q_r.cmp_s2 && !q_r.cmp_s3;
	assign osc_rise = q_r.osc_s2 && !q_r.osc_s3;
	assign div_tick = (q_r.div12 == `T3RT_DIV12_LAST);
	assign osc_tick = osc_rise && (q_r.osc8 == `T3RT_OSC8_LAST);

	// The external count source follows the source select field.
	always_comb begin
		unique case (q_r.ctrl[`T3RT_CTL_SRC_HI:`T3RT_CTL_SRC_LO])
			2'h0: ext_tick = div_tick;
			2'h1: ext_tick = osc_tick;
			2'h2: ext_tick = div_tick;
			2'h3: ext_tick = cmp_rise;
		endcase
	end

	// Capture trigger, and per-byte choice between system clock and source.
	assign cap_evt = q_r.ctrl[`T3RT_CTL_SRC_HI] ? osc_tick : cmp_rise;
	assign lo_tick = q_r.clksel[`T3RT_CKS_LO] ? 1'b1 : ext_tick;
	assign hi_tick = q_r.clksel[`T3RT_CKS_HI] ? 1'b1 : ext_tick;
	assign cap_mode = q_r.ctrl[`T3RT_CTL_CAP];
	assign split = q_r.ctrl[`T3RT_CTL_SPLIT] && !cap_mode;

	// ***************************************************************
	// Bus decode
	// ***************************************************************

	// A write is performed once address and data are both held.
	assign do_wr = q_r.aw_held && q_r.w_held && !q_r.bvalid;
	assign wr_en = do_wr && q_r.w_strb0;
	// Decode ignores any page selection; only the index matters.
	assign cnt_wr = wr_en && ((q_r.aw_idx == `T3RT_IDX_CNTL) ||
		(q_r.aw_idx == `T3RT_IDX_CNTH));
	assign ctrl_wr = wr_en && (q_r.aw_idx == `T3RT_IDX_CTRL);
	assign ar_idx = AXI_ARADDR_I[11:2];

	// Read multiplexer; unmapped indices answer with an error.
	always_comb begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		unique case (ar_idx)
			`T3RT_IDX_CTRL: rd_byte = q_r.ctrl;
			`T3RT_IDX_RLL: rd_byte = q_r.rl[7:0];
			`T3RT_IDX_RLH: rd_byte = q_r.rl[15:8];
			`T3RT_IDX_CNTL: rd_byte = q_r.cnt[7:0];
			`T3RT_IDX_CNTH: rd_byte = q_r.cnt[15:8];
			`T3RT_IDX_CLKSEL: rd_byte = {6'h00, q_r.clksel};
			`T3RT_IDX_STATUS: rd_byte = {5'h00, q_r.status};
			`T3RT_IDX_MASK: rd_byte = {5'h00, q_r.mask};
			default: rd_hit = 1'b0;
		endcase
	end

	// ***************************************************************
	// Next state
	// ***************************************************************

	// Computes the complete next state from the current one.
	always_comb begin
		logic set_h;
		logic set_l;
		logic set_c;
		set_h = 1'b0;
		set_l = 1'b0;
		set_c = 1'b0;
		q_nxt = q_r;
		q_nxt.cmp_s1 = CMP1_I;
		q_nxt.cmp_s2 = q_r.cmp_s1;
		q_nxt.cmp_s3 = q_r.cmp_s2;
		q_nxt.osc_s1 = EXTOSC_I;
		q_nxt.osc_s2 = q_r.osc_s1;
		q_nxt.osc_s3 = q_r.osc_s2;
		q_nxt.div12 = div_tick ? 4'h0 : q_r.div12 + 4'h1;
		if (osc_rise) begin
			q_nxt.osc8 = q_r.osc8 + 3'h1;
		end
		// Bus write address and data channels, taken in either order.
		if (AXI_AWVALID_I && q_r.awready) begin
			q_nxt.aw_held = 1'b1;
			q_nxt.aw_idx = AXI_AWADDR_I[11:2];
		end
		if (AXI_WVALID_I && q_r.wready) begin
			q_nxt.w_held = 1'b1;
			q_nxt.w_data = AXI_WDATA_I[7:0];
			q_nxt.w_strb0 = AXI_WSTRB_I[0];
		end
		if (q_r.bvalid && AXI_BREADY_I) begin
			q_nxt.bvalid = 1'b0;
		end
		// Register writes, each in the low byte lane.
		if (do_wr) begin
			q_nxt.aw_held = 1'b0;
			q_nxt.w_held = 1'b0;
			q_nxt.bvalid = 1'b1;
			q_nxt.bresp = `T3RT_RESP_OKAY;
			unique case (q_r.aw_idx)
				`T3RT_IDX_CTRL: begin
					if (wr_en) q_nxt.ctrl = q_r.w_data;
				end
				`T3RT_IDX_RLL: begin
					if (wr_en) q_nxt.rl[7:0] = q_r.w_data;
				end
				`T3RT_IDX_RLH: begin
					if (wr_en) q_nxt.rl[15:8] = q_r.w_data;
				end
				`T3RT_IDX_CNTL: begin
					if (wr_en) q_nxt.cnt[7:0] = q_r.w_data;
				end
				`T3RT_IDX_CNTH: begin
					if (wr_en) q_nxt.cnt[15:8] = q_r.w_data;
				end
				`T3RT_IDX_CLKSEL: begin
					if (wr_en) q_nxt.clksel = q_r.w_data[1:0];
				end
				`T3RT_IDX_STATUS: begin
					if (wr_en) q_nxt.status = q_r.status & ~q_r.w_data[2:0];
				end
				`T3RT_IDX_MASK: begin
					if (wr_en) q_nxt.mask = q_r.w_data[2:0];
				end
				default: q_nxt.bresp = `T3RT_RESP_SLVERR;
			endcase
		end
		// Counting; a counter byte write takes that cycle instead.
		if (!cnt_wr) begin
			if (split) begin
				if (lo_tick) begin
					if (q_r.cnt[7:0] == 8'hff) begin
						q_nxt.cnt[7:0] = q_r.rl[7:0];
						set_l = 1'b1;
					end else begin
						q_nxt.cnt[7:0] = q_r.cnt[7:0] + 8'h01;
					end
				end
				if (q_r.ctrl[`T3RT_CTL_RUN] && hi_tick) begin
					if (q_r.cnt[15:8] == 8'hff) begin
						q_nxt.cnt[15:8] = q_r.rl[15:8];
						set_h = 1'b1;
					end else begin
						q_nxt.cnt[15:8] = q_r.cnt[15:8] + 8'h01;
					end
				end
			end else if (q_r.ctrl[`T3RT_CTL_RUN] && lo_tick) begin
				set_l = (q_r.cnt[7:0] == 8'hff);
				if (q_r.cnt == 16'hffff) begin
					q_nxt.cnt = cap_mode ? `T3RT_RST_CNT : q_r.rl;
					set_h = !cap_mode;
				end else begin
					q_nxt.cnt = q_r.cnt + 16'h0001;
				end
			end
		end
		// Capture overrides any reload write in the same cycle.
		if (cap_mode && cap_evt) begin
			q_nxt.rl = q_r.cnt;
			set_h = 1'b1;
			set_c = 1'b1;
		end
		// Hardware sets win over a software write of the flags.
		if (set_h) q_nxt.ctrl[`T3RT_CTL_TFH] = 1'b1;
		if (set_l) q_nxt.ctrl[`T3RT_CTL_TFL] = 1'b1;
		q_nxt.status = q_nxt.status | {set_c, set_l, set_h};
		// Interrupt; low overflow counts only with its enable set.
		q_nxt.irq = |(q_r.status & q_r.mask & {1'b1, q_r.ctrl[`T3RT_CTL_LIE], 1'b1});
		// Bus read channel.
		if (q_r.rvalid && AXI_RREADY_I) begin
			q_nxt.rvalid = 1'b0;
		end
		if (AXI_ARVALID_I && q_r.arready) begin
			q_nxt.rvalid = 1'b1;
			q_nxt.rdata = rd_byte;
			q_nxt.rresp = rd_hit ? `T3RT_RESP_OKAY : `T3RT_RESP_SLVERR;
		end
		q_nxt.awready = !q_nxt.aw_held && !q_nxt.bvalid;
		q_nxt.wready = !q_nxt.w_held && !q_nxt.bvalid;
		q_nxt.arready = !q_nxt.rvalid;
	end

	// ***************************************************************
	// State register
	// ***************************************************************

	// Registers the state; the clock enable freezes every field.
	always_ff @(posedge CORE_CLK_I or negedge rstn_r) begin
		if (!rstn_r) begin
			q_r <= '0;
		end else if (CE_I) begin
			q_r <= q_nxt;
		end
	end

	// Outputs come straight from the state register.
	assign AXI_AWREADY_O = q_r.awready;
	assign AXI_WREADY_O = q_r.wready;
	assign AXI_BRESP_O = q_r.bresp;
	assign AXI_BVALID_O = q_r.bvalid;
	assign AXI_ARREADY_O = q_r.arready;
	assign AXI_RDATA_O = {24'h000000, q_r.rdata};
	assign AXI_RRESP_O = q_r.rresp;
	assign AXI_RVALID_O = q_r.rvalid;
	assign IRQ_O = q_r.irq;

	// ***************************************************************
	// Assertions
	// ***************************************************************

	default clocking a_clk @(posedge CORE_CLK_I); endclocking
	default disable iff (!rstn_r || !CE_I);

	// Checks on counting, flags, interrupt level and bus answers.
	a_low_irq_gate: assert property (!q_r.ctrl[`T3RT_CTL_LIE]
		&& ((q_r.status & q_r.mask & 3'h5) == 3'h0) |=> !q_r.irq)
		else $error("low overflow raised irq while disabled");
	a_capture_copy: assert property (cap_mode && cap_evt |=>
		(q_r.rl == $past(q_r.cnt)) && q_r.ctrl[`T3RT_CTL_TFH])
		else $error("capture did not copy count");
	a_wrap_reload: assert property (!split && !cap_mode && q_r.ctrl[`T3RT_CTL_RUN]
		&& lo_tick && !cnt_wr && (q_r.cnt == 16'hffff) |=> (q_r.cnt == $past(q_r.rl))
		&& q_r.ctrl[`T3RT_CTL_TFH]) else $error("16-bit rollover wrong");
	a_split_free: assert property (split && !q_r.ctrl[`T3RT_CTL_RUN] && lo_tick
		&& !cnt_wr && (q_r.cnt[7:0] != 8'hff) |=>
		q_r.cnt[7:0] == $past(q_r.cnt[7:0]) + 8'h01)
		else $error("split low byte did not count");
	a_run_hold: assert property (!q_r.ctrl[`T3RT_CTL_RUN] && !cnt_wr |=>
		$stable(q_r.cnt[15:8])) else $error("high byte moved while stopped");
	a_split_reload: assert property (split && lo_tick && !cnt_wr
		&& (q_r.cnt[7:0] == 8'hff) |=> (q_r.cnt[7:0] == $past(q_r.rl[7:0]))
		&& q_r.ctrl[`T3RT_CTL_TFL]) else $error("split low reload wrong");
	a_flag_sticky: assert property (q_r.ctrl[`T3RT_CTL_TFH] && !ctrl_wr |=>
		q_r.ctrl[`T3RT_CTL_TFH]) else $error("high flag cleared by hardware");
	a_cnt_write: assert property (cnt_wr && (q_r.aw_idx == `T3RT_IDX_CNTL) |=>
		q_r.cnt[7:0] == $past(q_r.w_data)) else $error("count write lost");
	a_div_rate: assert property (div_tick |=> !div_tick [*8] ##1 !div_tick [*3]
		##1 div_tick) else $error("divide by twelve period wrong");
	a_sync_edge: assert property (cmp_rise |-> $past(CMP1_I, 2) && !$past(CMP1_I, 3))
		else $error("comparator edge not synchronised");
	a_low_sticky: assert property (q_r.ctrl[`T3RT_CTL_TFL] && !ctrl_wr |=>
		q_r.ctrl[`T3RT_CTL_TFL]) else $error("low flag cleared by hardware");
	a_status_keep: assert property (!(wr_en && (q_r.aw_idx == `T3RT_IDX_STATUS)) |=>
		(q_r.status & $past(q_r.status)) == $past(q_r.status))
		else $error("status bit cleared by hardware");
	a_low_irq_on: assert property (q_r.status[`T3RT_ST_LOW] && q_r.mask[`T3RT_ST_LOW]
		&& q_r.ctrl[`T3RT_CTL_LIE] |=> q_r.irq) else $error("low interrupt not raised");
	a_fast_count: assert property (q_r.clksel[`T3RT_CKS_LO] && !split && !cnt_wr
		&& q_r.ctrl[`T3RT_CTL_RUN] && (q_r.cnt != 16'hffff) |=>
		q_r.cnt == $past(q_r.cnt) + 16'h0001) else $error("every-clock count missed");
	a_read_answer: assert property (AXI_ARVALID_I && q_r.arready |=> q_r.rvalid)
		else $error("read not answered");

	c_capture: cover property (cap_mode && cap_evt);
	c_osc_capture: cover property (cap_mode && cap_evt && q_r.ctrl[`T3RT_CTL_SRC_HI]);
	c_wrap16: cover property (!split && q_r.ctrl[`T3RT_CTL_RUN] && lo_tick
		&& (q_r.cnt == 16'hffff));
	c_split_wrap: cover property (split && lo_tick && (q_r.cnt[7:0] == 8'hff));
	c_irq: cover property (!q_r.irq ##1 q_r.irq);

endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
`include "t3rt_map.svh"

// Counts one comparison and reports a mismatch on the spot.
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %0t %s", $time, m); end end

module testbench;
	logic clk = 1'b0;
	logic rstn_n = 1'b0;
	logic cmp = 1'b0;
	logic osc = 1'b0;
	logic osc_en = 1'b0;
	logic [1:0] oc = 2'h0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] rdv;
	logic [1:0] rsp;
	logic [15:0] a16;
	int err_count = 0;
	int n_tests = 0;

	// ****************************************************************
	// Clock, oscillator stand-in and the block itself.
	// ****************************************************************
	always #4 clk = ~clk;

	// Oscillator with a period of four system clocks while enabled.
	always @(posedge clk) begin
		oc <= oc + 2'h1;
		osc <= osc_en & oc[1];
	end

	t3rt_timer u_t3rt_timer (.CORE_CLK_I(clk), .RSTN_I(rstn_n), .CE_I(1'b1), .CMP1_I(cmp),
		.EXTOSC_I(osc), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
		.AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb),
		.AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp),
		.AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr),
		.AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata),
		.AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready), .IRQ_O(irq));

	// ****************************************************************
	// Bus tasks.
	// ****************************************************************
	// Writes one byte register; the response code lands in rsp.
	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk);
		awaddr <= {i, 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1 && !ad) begin ad = 1'b1; awvalid <= 1'b0; end
			if (wready === 1'b1 && !wd) begin wd = 1'b1; wvalid <= 1'b0; end
		end while (!(ad && wd));
		do @(posedge clk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	// Reads one byte register into rdv; the response code lands in rsp.
	task automatic rd(input logic [9:0] i);
		@(posedge clk);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rdv = rdata[7:0];
		rsp = rresp;
		rready <= 1'b0;
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	// Reset values, read-back and an unmapped place.
	task automatic t_regs();
		for (int i = 'h91; i <= 'h95; i++) begin
			rd(i[9:0]);
			`CHK({rsp, rdv}, 10'h000, "reset value")
		end
		wr(`T3RT_IDX_RLL, 8'ha5);
		rd(`T3RT_IDX_RLL);
		`CHK(rdv, 8'ha5, "reload low read back")
		wr(10'h0a0, 8'h11);
		`CHK(rsp, 2'h2, "unmapped write answer")
		rd(10'h0a0);
		`CHK({rsp, rdv}, 10'h200, "unmapped read answer")
		$display("test regs done");
	endtask

	// Sixteen-bit rollover reloads and flags; stopping holds the count.
	task automatic t_roll();
		wr(`T3RT_IDX_RLH, 8'h12);
		wr(`T3RT_IDX_RLL, 8'h00);
		wr(`T3RT_IDX_CNTL, 8'hfe);
		wr(`T3RT_IDX_CNTH, 8'hff);
		wr(`T3RT_IDX_CLKSEL, 8'h03);
		wr(`T3RT_IDX_CTRL, 8'h04);
		wait_clk(20);
		rd(`T3RT_IDX_CTRL);
		`CHK(rdv[7:6], 2'h3, "overflow flags after rollover")
		wr(`T3RT_IDX_CTRL, 8'h00);
		rd(`T3RT_IDX_CNTH);
		`CHK(rdv, 8'h12, "high byte loaded from reload")
		rd(`T3RT_IDX_CNTL);
		a16[7:0] = rdv;
		wait_clk(30);
		rd(`T3RT_IDX_CNTL);
		`CHK(rdv, a16[7:0], "count held while stopped")
		$display("test roll done");
	endtask

	// Split mode: the low byte runs and reloads alone, the high byte waits.
	task automatic t_split();
		wr(`T3RT_IDX_CNTH, 8'h55);
		wr(`T3RT_IDX_RLL, 8'hf0);
		wr(`T3RT_IDX_CTRL, 8'h08);
		wait_clk(300);
		rd(`T3RT_IDX_CNTL);
		`CHK(rdv >= 8'hf0, 1'b1, "low byte reloads from its own byte")
		rd(`T3RT_IDX_CNTH);
		`CHK(rdv, 8'h55, "high byte stopped")
		rd(`T3RT_IDX_CTRL);
		`CHK(rdv[6], 1'b1, "low overflow flag")
		wr(`T3RT_IDX_CTRL, 8'h00);
		$display("test split done");
	endtask

	// Interrupt masking, the low-byte enable and clearing by writing ones.
	task automatic t_irq();
		wr(`T3RT_IDX_MASK, 8'h00);
		wait_clk(3);
		`CHK(irq, 1'b0, "masked interrupt stays low")
		wr(`T3RT_IDX_MASK, 8'h02);
		wait_clk(3);
		`CHK(irq, 1'b0, "low interrupt without its enable")
		wr(`T3RT_IDX_CTRL, 8'h20);
		wait_clk(3);
		`CHK(irq, 1'b1, "low interrupt with its enable")
		wr(`T3RT_IDX_STATUS, 8'h07);
		wait_clk(3);
		`CHK(irq, 1'b0, "interrupt cleared by software")
		$display("test irq done");
	endtask

	// Capture on a comparator rising edge, and none while capture is off.
	task automatic t_cap();
		wr(`T3RT_IDX_CTRL, 8'h04);
		cmp <= 1'b1;
		wait_clk(20);
		cmp <= 1'b0;
		rd(`T3RT_IDX_RLH);
		`CHK(rdv, 8'h12, "no capture in reload operation")
		wr(`T3RT_IDX_CNTL, 8'h00);
		wr(`T3RT_IDX_CNTH, 8'h00);
		wr(`T3RT_IDX_STATUS, 8'h07);
		wr(`T3RT_IDX_CTRL, 8'h14);
		wait_clk(20);
		cmp <= 1'b1;
		wait_clk(20);
		wr(`T3RT_IDX_CTRL, 8'h00);
		rd(`T3RT_IDX_RLL);
		a16 = {8'h00, rdv};
		rd(`T3RT_IDX_RLH);
		`CHK(rdv, 8'h00, "captured high byte")
		rd(`T3RT_IDX_CNTL);
		`CHK((a16 > 16'h0010) && (a16[7:0] < rdv), 1'b1, "captured count")
		rd(`T3RT_IDX_STATUS);
		`CHK(rdv[2:0], 3'h5, "capture and high flag status")
		cmp <= 1'b0;
		$display("test capture done");
	endtask

	// Each source code on a slow clock, counted over 256 system clocks.
	task automatic t_src();
		logic [7:0] lo, hi;
		wr(`T3RT_IDX_CLKSEL, 8'h00);
		osc_en <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			lo = (s == 1) ? 8'h07 : (s == 3) ? 8'h00 : 8'h14;
			hi = (s == 1) ? 8'h09 : (s == 3) ? 8'h00 : 8'h17;
			wr(`T3RT_IDX_CNTL, 8'h00);
			wr(`T3RT_IDX_CTRL, {6'h01, s[1:0]});
			wait_clk(256);
			wr(`T3RT_IDX_CTRL, 8'h00);
			rd(`T3RT_IDX_CNTL);
			`CHK((rdv >= lo) && (rdv <= hi), 1'b1, "ticks of selected source")
		end
		// Capture triggered by the divided oscillator while counting every clock.
		wr(`T3RT_IDX_STATUS, 8'h07);
		wr(`T3RT_IDX_CLKSEL, 8'h01);
		wr(`T3RT_IDX_CTRL, 8'h16);
		wait_clk(100);
		wr(`T3RT_IDX_CTRL, 8'h00);
		rd(`T3RT_IDX_STATUS);
		`CHK(rdv[2:0], 3'h5, "oscillator capture trigger")
		osc_en <= 1'b0;
		$display("test sources done");
	endtask

	// ****************************************************************
	// Verdict, watchdog and main sequence.
	// ****************************************************************
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Cuts a hang short well after the tests should have ended.
	initial begin
		#400000;
		err_count++;
		end_of_test();
	end

	initial begin
		wait_clk(3);
		rstn_n <= 1'b1;
		wait_clk(4);
		t_regs();
		t_roll();
		t_split();
		t_irq();
		t_cap();
		t_src();
		end_of_test();
	end
endmodule
